// ---- dv/rsse_exec_monitor.sv ----
`timescale 1ns/10ps
module rsse_exec_monitor
	import rsse_pkg::*;
(
	// Instruction side
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic instr_valid,
	input wire logic [2:0] instr_op,
	input wire logic instr_dest,
	input wire logic [7:0] freg_rdata,
	input wire logic [12:0] stack_top,
	// Core state
	input wire logic freg_we,
	input wire logic stack_pop,
	input wire logic [7:0] acc_reg,
	input wire logic [12:0] pc_reg,
	input wire logic carry_reg,
	input wire logic dcarry_reg,
	input wire logic zero_reg,
	input wire logic timeout_status_bit,
	input wire logic powerdown_status_bit,
	input wire logic watchdog_clear,
	input wire logic osc_stop,
	input wire logic instr_ready
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire logic go = instr_valid && instr_ready;
	sequence s_rot; go && instr_op == RSSE_OP_ROTATE_RIGHT_CARRY; endsequence
	sequence s_sub; go && instr_op == RSSE_OP_SUBTRACT_ACC_FROM_REG; endsequence
	sequence s_slp; go && instr_op == RSSE_OP_SLEEP; endsequence
	sequence s_ret; go && instr_op == RSSE_OP_RETURN_WITH_LITERAL; endsequence
	property p_rot_c; s_rot |=> carry_reg == $past(freg_rdata[0]); endproperty
	a_rot_c: assert property (p_rot_c) else $error("rotate carry wrong");
	property p_rot_w;
		s_rot ##0 !instr_dest |=> acc_reg == {$past(carry_reg), $past(freg_rdata[7:1])} && !freg_we;
	endproperty
	a_rot_w: assert property (p_rot_w) else $error("rotate result wrong");
	property p_rot_f; s_rot |=> $stable(zero_reg) && $stable(dcarry_reg); endproperty
	a_rot_f: assert property (p_rot_f) else $error("rotate touched flags");
	property p_sub; s_sub ##0 !instr_dest |=> acc_reg == $past(freg_rdata) - $past(acc_reg); endproperty
	a_sub: assert property (p_sub) else $error("subtract result wrong");
	property p_sub_c; s_sub |=> carry_reg == ($past(acc_reg) <= $past(freg_rdata)); endproperty
	a_sub_c: assert property (p_sub_c) else $error("subtract carry wrong");
	property p_wdt; s_slp |=> watchdog_clear ##1 !watchdog_clear; endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog not cleared");
	property p_stat; s_slp |=> timeout_status_bit && !powerdown_status_bit; endproperty
	a_stat: assert property (p_stat) else $error("sleep status wrong");
	property p_halt; s_slp |=> osc_stop && !instr_ready; endproperty
	a_halt: assert property (p_halt) else $error("sleep did not halt");
	property p_ret; s_ret |=> stack_pop && !instr_ready ##1 pc_reg == $past(stack_top); endproperty
	a_ret: assert property (p_ret) else $error("return pop wrong");
endmodule : rsse_exec_monitor
bind rsse_exec rsse_exec_monitor i_rsse_exec_monitor (.*);

// ---- dv/test_rotate_subtract_sleep_exec.sv ----
`timescale 1ns/10ps
module test_rotate_subtract_sleep_exec;
	import rsse_pkg::*;
	logic clk, sys_rst, instr_valid, instr_dest, wake_req, freg_we, stack_pop, carry_reg;
	logic dcarry_reg, zero_reg, timeout_status_bit, powerdown_status_bit, watchdog_clear;
	logic osc_stop, instr_ready, took, alu_v, c, dc, z;
	logic [2:0] instr_op;
	logic [6:0] instr_faddr, freg_raddr, freg_waddr;
	logic [7:0] instr_literal, freg_rdata, freg_wdata, acc_reg, a, k;
	logic [12:0] stack_top, pc_reg;
	logic [26:0] exp_q[$];
	int fails, n_tests;
	rsse_exec i_rsse_exec (.*);
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			fails++;
			$display("ERROR %s exp %h seen %h", nm, e, s);
		end
	endtask : chk
	task conclude;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : conclude
	// Reference model of one arithmetic instruction, then drive it
	task alu(input logic [2:0] op, input logic d, input logic [6:0] fa, input logic [7:0] f);
		logic [7:0] r;
		logic w;
		if (op == RSSE_OP_ROTATE_RIGHT_CARRY) begin
			{r, c} = {c, f};
		end else if (op == RSSE_OP_SUBTRACT_ACC_FROM_REG) begin
			r = f - a;
			c = a <= f;
			dc = a[3:0] <= f[3:0];
		end else begin
			{c, r} = {1'b0, f} + {1'b0, a};
			dc = {1'b0, f[3:0]} + {1'b0, a[3:0]} > 5'h0F;
		end
		if (op != RSSE_OP_ROTATE_RIGHT_CARRY) z = r == 8'h00;
		if (!d) a = r;
		w = d && fa != RSSE_PCL_ADDR;
		exp_q.push_back({w, w ? fa : 7'h00, w ? r : 8'h00, a, c, dc, z});
		@(posedge clk);
		instr_valid <= 1'b1;
		instr_op <= op;
		instr_dest <= d;
		instr_faddr <= fa;
		freg_rdata <= f;
		alu_v <= 1'b1;
	endtask : alu
	task idle;
		@(posedge clk);
		instr_valid <= 1'b0;
		alu_v <= 1'b0;
	endtask : idle
	always @(posedge clk) took <= instr_valid && instr_ready && alu_v;
	always @(negedge clk) begin
		if (took === 1'b1) begin
			chk("alu", {freg_we, freg_we ? freg_waddr : 7'h00, freg_we ? freg_wdata : 8'h00,
				acc_reg, carry_reg, dcarry_reg, zero_reg}, exp_q.pop_front());
		end
	end
	initial begin
		void'($urandom(14658));
		{sys_rst, instr_valid, instr_dest, wake_req, alu_v, took} = 6'h20;
		instr_op = RSSE_OP_NONE;
		{instr_faddr, instr_literal, freg_rdata, stack_top} = 36'h0;
		{a, c, dc, z, k} = 19'h0;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (40) alu(3'($urandom_range(3, 1)), 1'($urandom), {1'b1, 6'($urandom)}, 8'($urandom));
		// Equal operands: carry set, zero set
		alu(RSSE_OP_SUBTRACT_ACC_FROM_REG, 1'b0, 7'h40, a);
		idle;
		$display("arithmetic test done");
		k = 8'($urandom);
		@(posedge clk);
		instr_valid <= 1'b1;
		instr_op <= RSSE_OP_RETURN_WITH_LITERAL;
		instr_literal <= k;
		stack_top <= 13'h0A5C;
		idle;
		@(posedge clk);
		@(negedge clk);
		chk("return", {pc_reg, acc_reg}, {13'h0A5C, k});
		a = k;
		alu(RSSE_OP_ADD_ACC_TO_REG, 1'b1, RSSE_PCL_ADDR, 8'h5C);
		idle;
		@(negedge clk);
		chk("jump", pc_reg[7:0], 8'(8'h5C + k));
		$display("table jump test done");
		@(posedge clk);
		instr_valid <= 1'b1;
		instr_op <= RSSE_OP_SLEEP;
		idle;
		@(negedge clk);
		chk("sleep", {watchdog_clear, timeout_status_bit, powerdown_status_bit, osc_stop,
			instr_ready}, 5'h1A);
		repeat (3) @(negedge clk);
		chk("halted", {watchdog_clear, osc_stop, instr_ready}, 3'h2);
		@(posedge clk);
		wake_req <= 1'b1;
		for (int i = 0; i < 8 && instr_ready !== 1'b1; i++) @(posedge clk);
		wake_req <= 1'b0;
		@(negedge clk);
		chk("wake", {osc_stop, instr_ready}, 2'h1);
		alu(RSSE_OP_ROTATE_RIGHT_CARRY, 1'b0, 7'h41, 8'h01);
		idle;
		repeat (2) @(posedge clk);
		$display("sleep test done");
		chk("queue", exp_q.size(), 0);
		conclude();
	end
	// Whole run is about 65 cycles
	initial begin
		#40000;
		fails++;
		conclude();
	end
endmodule : test_rotate_subtract_sleep_exec

// ---- rtl/rsse_alu.sv ----
`timescale 1ns/10ps
module rsse_alu
	import rsse_pkg::*;
(
	// Operands
	input wire logic [2:0] op,
	input wire logic [7:0] freg,
	input wire logic [7:0] acc,
	input wire logic carry_in,
	// Results
	output logic [7:0] result,
	output logic carry_out,
	output logic dcarry_out,
	output logic zero_out
);
	logic [8:0] sum9;
	logic [4:0] sum5;
	always_comb begin
		sum9 = 9'h000;
		sum5 = 5'h00;
		result = freg;
		carry_out = carry_in;
		dcarry_out = 1'b0;
		case (op)
			// RL1 rotate through carry
			RSSE_OP_ROTATE_RIGHT_CARRY: begin
				result = {carry_in, freg[7:1]};
				carry_out = freg[0];
			end
			// RL4 two's complement subtract
			RSSE_OP_SUBTRACT_ACC_FROM_REG: begin
				sum9 = {1'b0, freg} + {1'b0, ~acc} + 9'h001;
				sum5 = {1'b0, freg[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
				result = sum9[7:0];
				// RL5 borrow-inverted carry
				carry_out = sum9[8];
				dcarry_out = sum5[4];
			end
			RSSE_OP_ADD_ACC_TO_REG: begin
				sum9 = {1'b0, freg} + {1'b0, acc};
				sum5 = {1'b0, freg[3:0]} + {1'b0, acc[3:0]};
				result = sum9[7:0];
				carry_out = sum9[8];
				dcarry_out = sum5[4];
			end
			default: begin
				result = freg;
			end
		endcase
		zero_out = (result == 8'h00);
	end
endmodule : rsse_alu

// ---- rtl/rsse_exec.sv ----
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
// Function
// RL1: Rotate right shifts the addressed file register through carry, old carry into bit 7.
// RL2: Rotate right writes the register when the destination bit is 1, else the accumulator. With d=1 at RSSE_PCL_ADDR the code writes nothing.
// RL3: Rotate right changes only carry among the status bits.
// RL4: Subtract computes register minus accumulator, into accumulator (d=0) or register (d=1). With d=1 at RSSE_PCL_ADDR the code writes nothing.
// RL5: Subtract sets carry when acc <= reg, digit-carry from the nibbles, zero from the result.
// RL6: Sleep clears the watchdog counter and its prescaler.
// RL7: Sleep sets the timeout status bit and clears the power-down status bit.
// RL8: After sleep, execution halts and the oscillator stops until a wake-up.
// RL9: Adding the accumulator to the program counter makes a computed jump.
// RL10: Return with literal loads the literal into acc and pops the stack into pc in two cycles.
module rsse_exec
	import rsse_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Decoded instruction
	input wire logic instr_valid,
	input wire logic [2:0] instr_op,
	input wire logic [6:0] instr_faddr,
	input wire logic instr_dest,
	input wire logic [7:0] instr_literal,
	// File register read port, same clock
	input wire logic [7:0] freg_rdata,
	output logic [6:0] freg_raddr,
	// File register write port
	output logic freg_we,
	output logic [6:0] freg_waddr,
	output logic [7:0] freg_wdata,
	// Stack
	input wire logic [12:0] stack_top,
	output logic stack_pop,
	// Wake-up from outside the core
	input wire logic wake_req,
	// Status and state
	output logic [7:0] acc_reg,
	output logic [12:0] pc_reg,
	output logic carry_reg,
	output logic dcarry_reg,
	output logic zero_reg,
	output logic timeout_status_bit,
	output logic powerdown_status_bit,
	output logic watchdog_clear,
	output logic osc_stop,
	output logic instr_ready
);
	typedef enum logic [2:0] {
		RSSE_ST_RUN = 3'b001,
		RSSE_ST_RET2 = 3'b010,
		RSSE_ST_SLEEP = 3'b100
	} rsse_state_e;

	rsse_state_e state_reg;
	rsse_state_e state_next;
	logic [7:0] alu_result;
	logic alu_c;
	logic alu_dc;
	logic alu_z;
	logic exec;
	logic wake_meta_reg;
	logic wake_sync_reg;
	logic [7:0] pcl_val;

	// Wake request comes from another domain
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wake_meta_reg <= 1'b0;
			wake_sync_reg <= 1'b0;
		end else begin
			wake_meta_reg <= wake_req;
			wake_sync_reg <= wake_meta_reg;
		end
	end

	// The low program counter byte reads through the file space
	assign pcl_val = pc_reg[7:0];
	assign freg_raddr = instr_faddr;
	assign exec = instr_valid && (state_reg == RSSE_ST_RUN);
	// RL8 no execution outside run
	assign instr_ready = (state_reg == RSSE_ST_RUN);

	rsse_alu u_alu (
		.op(instr_op),
		.freg((instr_faddr == RSSE_PCL_ADDR) ? pcl_val : freg_rdata),
		.acc(acc_reg),
		.carry_in(carry_reg),
		.result(alu_result),
		.carry_out(alu_c),
		.dcarry_out(alu_dc),
		.zero_out(alu_z)
	);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			RSSE_ST_RUN: begin
				if (exec && instr_op == RSSE_OP_RETURN_WITH_LITERAL) begin
					state_next = RSSE_ST_RET2;
				end else if (exec && instr_op == RSSE_OP_SLEEP) begin
					state_next = RSSE_ST_SLEEP;
				end
			end
			RSSE_ST_RET2: begin
				state_next = RSSE_ST_RUN;
			end
			// RL8 held until wake
			RSSE_ST_SLEEP: begin
				if (wake_sync_reg) begin
					state_next = RSSE_ST_RUN;
				end
			end
			default: begin
				state_next = RSSE_ST_RUN;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_reg <= RSSE_ST_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	// Accumulator updates
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			acc_reg <= RSSE_ACC_RST;
		end else if (exec) begin
			case (instr_op)
				// RL2 RL4 destination select
				RSSE_OP_ROTATE_RIGHT_CARRY, RSSE_OP_SUBTRACT_ACC_FROM_REG,
				RSSE_OP_ADD_ACC_TO_REG: begin
					if (!instr_dest) begin
						acc_reg <= alu_result;
					end
				end
				// RL10 literal into acc
				RSSE_OP_RETURN_WITH_LITERAL: begin
					acc_reg <= instr_literal;
				end
				default: begin
					acc_reg <= acc_reg;
				end
			endcase
		end
	end

	// File register write-back, registered
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			freg_we <= 1'b0;
			freg_waddr <= 7'h00;
			freg_wdata <= 8'h00;
		end else begin
			freg_we <= 1'b0;
			// RL2 write back to file
			if (exec && instr_dest && instr_faddr != RSSE_PCL_ADDR &&
				(instr_op == RSSE_OP_ROTATE_RIGHT_CARRY ||
				instr_op == RSSE_OP_SUBTRACT_ACC_FROM_REG ||
				instr_op == RSSE_OP_ADD_ACC_TO_REG)) begin
				freg_we <= 1'b1;
				freg_waddr <= instr_faddr;
				freg_wdata <= alu_result;
			end
		end
	end

	// Program counter
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pc_reg <= RSSE_PC_RST;
		end else if (state_reg == RSSE_ST_RET2) begin
			// RL10 pop into pc
			pc_reg <= stack_top;
		end else if (exec) begin
			// RL9 computed jump
			if (instr_op == RSSE_OP_ADD_ACC_TO_REG && instr_dest &&
				instr_faddr == RSSE_PCL_ADDR) begin
				pc_reg <= {pc_reg[12:8], alu_result};
			end else if (instr_op != RSSE_OP_RETURN_WITH_LITERAL &&
				instr_op != RSSE_OP_SLEEP) begin
				pc_reg <= pc_reg + 13'h0001;
			end else if (instr_op == RSSE_OP_SLEEP) begin
				pc_reg <= pc_reg + 13'h0001;
			end
		end
	end

	// Pop is taken in the second return cycle
	assign stack_pop = (state_reg == RSSE_ST_RET2);

	// Arithmetic status flags
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			carry_reg <= 1'b0;
			dcarry_reg <= 1'b0;
			zero_reg <= 1'b0;
		end else if (exec) begin
			case (instr_op)
				// RL3 carry only
				RSSE_OP_ROTATE_RIGHT_CARRY: begin
					carry_reg <= alu_c;
				end
				// RL5 all three flags
				RSSE_OP_SUBTRACT_ACC_FROM_REG, RSSE_OP_ADD_ACC_TO_REG: begin
					carry_reg <= alu_c;
					dcarry_reg <= alu_dc;
					zero_reg <= alu_z;
				end
				default: begin
					carry_reg <= carry_reg;
				end
			endcase
		end
	end

	// Power status bits: set at power-on reset, changed by sleep
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			timeout_status_bit <= 1'b1;
			powerdown_status_bit <= 1'b1;
		end else if (exec && instr_op == RSSE_OP_SLEEP) begin
			// RL7 sleep status
			timeout_status_bit <= 1'b1;
			powerdown_status_bit <= 1'b0;
		end
	end

	// RL6 watchdog clear pulse
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			watchdog_clear <= 1'b0;
		end else begin
			watchdog_clear <= exec && (instr_op == RSSE_OP_SLEEP);
		end
	end

	// RL8 oscillator stop
	assign osc_stop = (state_reg == RSSE_ST_SLEEP);
endmodule : rsse_exec

// ---- rtl/rsse_pkg.sv ----
package rsse_pkg;
	// Operation select from the instruction decoder
	localparam logic [2:0] RSSE_OP_NONE = 3'h0;
	localparam logic [2:0] RSSE_OP_ROTATE_RIGHT_CARRY = 3'h1;
	localparam logic [2:0] RSSE_OP_SUBTRACT_ACC_FROM_REG = 3'h2;
	localparam logic [2:0] RSSE_OP_ADD_ACC_TO_REG = 3'h3;
	localparam logic [2:0] RSSE_OP_RETURN_WITH_LITERAL = 3'h4;
	localparam logic [2:0] RSSE_OP_SLEEP = 3'h5;
	// Widths
	localparam int RSSE_DATA_W = 8;
	localparam int RSSE_FADDR_W = 7;
	localparam int RSSE_PC_W = 13;
	// Reset values
	localparam logic [7:0] RSSE_ACC_RST = 8'h00;
	localparam logic [12:0] RSSE_PC_RST = 13'h0000;
	localparam logic [7:0] RSSE_WDT_CLEAR = 8'h00;
	// Address of the program counter low byte in the file space
	localparam logic [6:0] RSSE_PCL_ADDR = 7'h02;
	// Cycles taken by a return
	localparam logic [1:0] RSSE_RET_CYCLES = 2'h2;
endpackage : rsse_pkg
